// *** rtl/pis_pkg.sv ***
// constants, field positions and class codes of the priority interrupt sequencer
// assumes one machine clock shared with the instruction sequencer and memory
package pis_pkg;
   localparam int CC_W = 15;
   localparam int WORD_W = 25;
   localparam logic [14:0] CC_RESET = 15'h0000;
   localparam logic [14:0] PE_SAVE = 15'h0010;
   localparam logic [14:0] PE_VEC = 15'h0011;
   localparam logic [14:0] CT_SAVE = 15'h0012;
   localparam logic [14:0] CT_VEC = 15'h0013;
   localparam logic [14:0] IO_SAVE = 15'h0014;
   localparam logic [14:0] IO_VEC = 15'h0015;
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_CONT = 8'h04;
   localparam logic [7:0] REG_IO = 8'h08;
   localparam logic [7:0] REG_CC = 8'h0C;
   localparam int ST_PE_MASK = 0;
   localparam int ST_CT_MASK = 1;
   localparam int ST_IO_MASK = 2;
   localparam int ST_INHIBIT = 3;
   localparam int ST_HOLD = 4;
   localparam int ST_HALT = 5;
   localparam int ST_PE_ANY = 6;
   localparam int ST_CT_ANY = 7;
   localparam int ST_IO_ANY = 8;
   localparam int CONT_PE_LSB = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      CL_NONE = 2'b00,
      CL_IO = 2'b01,
      CL_CT = 2'b10,
      CL_PE = 2'b11
   } pis_class_e;
endpackage

// *** rtl/pis_io_channel.sv ***
// one input-output channel's specific indicators
// assumes events are one-cycle pulses from synchronizer logic on the same clock
`timescale 1ns/1ps
module pis_io_channel (
   input wire logic clock,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic init_evt,
   input wire logic done_evt,
   input wire logic fault_evt,
   input wire logic fs_intr,
   input wire logic clr,
   output logic init_ind_q,
   output logic done_ind_q,
   output logic fault_ind_q
);
   wire init_set = init_evt & fs_intr;
   wire done_set = done_evt & fs_intr & ~fault_evt & ~fault_ind_q;
   // a set in the clearing cycle wins
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         init_ind_q <= 1'b0;
         done_ind_q <= 1'b0;
         fault_ind_q <= 1'b0;
      end else if (clk_en) begin
         init_ind_q <= init_set | (init_ind_q & ~clr);
         done_ind_q <= done_set | (done_ind_q & ~clr);
         fault_ind_q <= fault_evt | (fault_ind_q & ~clr);
      end
   end
endmodule // pis_io_channel

// *** rtl/pis_sequencer.sv ***
// priority interrupt sequencer: indicators, class mask flags, boundary decision,
// control counter, save-word write and vector redirect, with an AXI4-Lite status port
// assumes instruction qualifiers are valid in the cycle instr_done is high
`timescale 1ns/1ps
module pis_sequencer #(
   parameter int NPE = 2,
   parameter int NCT = 7,
   parameter int NCH = 8
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic instr_done,
   input wire logic branch_valid,
   input wire logic [14:0] branch_addr,
   input wire logic fault_reset_instr,
   input wire logic contingency_reset_instr,
   input wire logic io_reset_instr,
   input wire logic io_inhibit_instr,
   input wire logic io_allow_instr,
   input wire logic [NPE-1:0] fault_evt,
   input wire logic [NCT-1:0] cont_evt,
   input wire logic [NCH-1:0] io_init_evt,
   input wire logic [NCH-1:0] io_done_evt,
   input wire logic [NCH-1:0] io_fault_evt,
   input wire logic [NCH-1:0] io_fs_intr,
   output logic [14:0] cc_q,
   output logic save_we_q,
   output logic [14:0] save_addr_q,
   output logic [24:0] save_data_q,
   output logic redirect_q,
   output logic [14:0] redirect_addr_q,
   output logic halt_q,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [NPE-1:0] pe_ind_q;
   logic [NCT-1:0] ct_ind_q;
   logic [NCH-1:0] io_init_q, io_done_q, io_fault_q;
   logic pe_mask_q, ct_mask_q, io_mask_q, inhibit_q, hold_q;
   pis_pkg::pis_class_e take_cls;
   logic [14:0] save_a, vec_a;

   // boundary and reset-instruction decode
   wire bnd = instr_done & clk_en & ~halt_q;
   wire any_rst = fault_reset_instr | contingency_reset_instr | io_reset_instr;
   wire sw_ct_set;
   wire [NCT-1:0] sw_ct_bits;
   wire pe_any = |pe_ind_q;
   wire ct_any = |ct_ind_q;
   wire io_any = |{io_init_q, io_done_q, io_fault_q};
   wire blk = any_rst;
   // probe in descending priority; a pending higher group stops lower tests
   wire take_pe = pe_any & ~pe_mask_q & ~blk;
   wire take_ct = ~pe_any & ct_any & ~pe_mask_q & ~ct_mask_q & ~blk;
   wire io_ok = ~pe_mask_q & ~ct_mask_q & ~io_mask_q & ~inhibit_q;
   wire take_io = ~pe_any & ~ct_any & io_any & io_ok & ~blk;
   wire take_any = take_pe | take_ct | take_io;
   wire [14:0] next_cc = branch_valid ? branch_addr : cc_q + 15'h0001;

   always_comb begin
      if (take_pe) take_cls = pis_pkg::CL_PE;
      else if (take_ct) take_cls = pis_pkg::CL_CT;
      else if (take_io) take_cls = pis_pkg::CL_IO;
      else take_cls = pis_pkg::CL_NONE;
   end

   always_comb begin
      case (take_cls)
         pis_pkg::CL_PE: begin
            save_a = pis_pkg::PE_SAVE;
            vec_a = pis_pkg::PE_VEC;
         end
         pis_pkg::CL_CT: begin
            save_a = pis_pkg::CT_SAVE;
            vec_a = pis_pkg::CT_VEC;
         end
         pis_pkg::CL_IO: begin
            save_a = pis_pkg::IO_SAVE;
            vec_a = pis_pkg::IO_VEC;
         end
         default: begin
            save_a = next_cc;
            vec_a = next_cc;
         end
      endcase
   end

   // indicators: a set in the same cycle as a reset instruction wins
   wire pe_clr = bnd & fault_reset_instr;
   wire ct_clr = bnd & contingency_reset_instr;
   wire io_clr = bnd & io_reset_instr;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pe_ind_q <= '0;
         ct_ind_q <= '0;
      end else if (clk_en) begin
         pe_ind_q <= fault_evt | (pe_ind_q & {NPE{~pe_clr}});
         ct_ind_q <= cont_evt | sw_ct_bits | (ct_ind_q & {NCT{~ct_clr}});
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++) begin : g_ch
         pis_io_channel u_ch (
            .clock(clock),
            .resetn(resetn),
            .clk_en(clk_en),
            .init_evt(io_init_evt[ch]),
            .done_evt(io_done_evt[ch]),
            .fault_evt(io_fault_evt[ch]),
            .fs_intr(io_fs_intr[ch]),
            .clr(io_clr),
            .init_ind_q(io_init_q[ch]),
            .done_ind_q(io_done_q[ch]),
            .fault_ind_q(io_fault_q[ch])
         );
      end
   endgenerate

   // mask flags have no software write path; reset instruction clears, take sets
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pe_mask_q <= 1'b0;
         ct_mask_q <= 1'b0;
         io_mask_q <= 1'b0;
         inhibit_q <= 1'b0;
         hold_q <= 1'b0;
      end else if (bnd) begin
         pe_mask_q <= take_pe | (pe_mask_q & ~fault_reset_instr);
         ct_mask_q <= take_ct | (ct_mask_q & ~contingency_reset_instr);
         io_mask_q <= take_io | (io_mask_q & ~io_reset_instr);
         inhibit_q <= io_inhibit_instr | (inhibit_q & ~io_allow_instr);
         hold_q <= any_rst;
      end
   end

   // control counter, save word and redirect, updated only at the boundary
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cc_q <= pis_pkg::CC_RESET;
         save_we_q <= 1'b0;
         save_addr_q <= '0;
         save_data_q <= '0;
         redirect_q <= 1'b0;
         redirect_addr_q <= '0;
      end else if (clk_en) begin
         save_we_q <= bnd & take_any;
         redirect_q <= bnd & take_any;
         if (bnd) begin
            cc_q <= take_any ? vec_a : next_cc;
            save_addr_q <= save_a;
            save_data_q <= {10'h000, next_cc};
            redirect_addr_q <= vec_a;
         end
      end
   end

   // a new processor error while its mask is set stops the processor
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) halt_q <= 1'b0;
      else if (clk_en && pe_mask_q && |fault_evt) halt_q <= 1'b1;
   end

   // AXI4-Lite slave: one write and one read at a time
   logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   wire aw_hs = s_axi_awvalid & awready_q;
   wire w_hs = s_axi_wvalid & wready_q;
   wire wr_go = aw_have_q & w_have_q & ~bvalid_q;
   wire wr_map = awaddr_q == pis_pkg::REG_CONT;
   wire wr_ro = awaddr_q == pis_pkg::REG_STATUS || awaddr_q == pis_pkg::REG_IO || awaddr_q == pis_pkg::REG_CC;
   assign sw_ct_set = wr_go & wr_map & wstrb_q[0];
   assign sw_ct_bits = sw_ct_set ? wdata_q[NCT-1:0] : '0;
   wire ar_hs = s_axi_arvalid & arready_q;
   wire [31:0] st_word = {23'h000000, io_any, ct_any, pe_any, halt_q, hold_q, inhibit_q,
                          io_mask_q, ct_mask_q, pe_mask_q};
   wire [31:0] ct_word = 32'(ct_ind_q) | (32'(pe_ind_q) << pis_pkg::CONT_PE_LSB);
   wire [31:0] io_word = 32'({io_fault_q, io_done_q, io_init_q});
   wire ra_st = s_axi_araddr == pis_pkg::REG_STATUS;
   wire ra_ct = s_axi_araddr == pis_pkg::REG_CONT;
   wire ra_io = s_axi_araddr == pis_pkg::REG_IO;
   wire ra_cc = s_axi_araddr == pis_pkg::REG_CC;
   wire ra_ok = ra_st | ra_ct | ra_io | ra_cc;
   wire [31:0] rd_mux = ra_st ? st_word : ra_ct ? ct_word : ra_io ? io_word : ra_cc ? 32'(cc_q) : 32'h00000000;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= pis_pkg::RESP_OKAY;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (clk_en) begin
         awready_q <= ~aw_have_q & ~aw_hs & ~awready_q;
         wready_q <= ~w_have_q & ~w_hs & ~wready_q;
         if (aw_hs) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (w_hs) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wr_map | wr_ro) ? pis_pkg::RESP_OKAY : pis_pkg::RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= pis_pkg::RESP_OKAY;
      end else if (clk_en) begin
         arready_q <= ~rvalid_q & ~ar_hs & ~arready_q;
         if (ar_hs) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= ra_ok ? pis_pkg::RESP_OKAY : pis_pkg::RESP_SLVERR;
         end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   a_pe_first_vec: assert property (@(posedge clock) disable iff (!resetn)
      bnd && pe_any && !pe_mask_q && !any_rst |=> redirect_q && redirect_addr_q == pis_pkg::PE_VEC)
      else $error("processor error not taken first");
   a_save_word_fmt: assert property (@(posedge clock) disable iff (!resetn)
      bnd && take_any |=> save_we_q && save_data_q == {10'h000, $past(next_cc)})
      else $error("saved word is not next address with zero upper bits");
   a_save_vec_pair: assert property (@(posedge clock) disable iff (!resetn)
      save_we_q |-> redirect_q && redirect_addr_q == save_addr_q + 15'h0001 && cc_q == redirect_addr_q)
      else $error("vector does not follow save word");
   a_mask_blocks_low: assert property (@(posedge clock) disable iff (!resetn)
      bnd && !pe_any && (pe_mask_q || ct_mask_q || (io_mask_q && !ct_any)) |=> !save_we_q && !redirect_q)
      else $error("lower class taken under mask");
   a_mask_set_take: assert property (@(posedge clock) disable iff (!resetn)
      bnd && take_ct |=> ct_mask_q && redirect_addr_q == pis_pkg::CT_VEC)
      else $error("contingency take did not set its mask");
   a_reset_clears: assert property (@(posedge clock) disable iff (!resetn)
      bnd && io_reset_instr |=> !io_mask_q)
      else $error("io reset left mask set");
   a_hold_after_rst: assert property (@(posedge clock) disable iff (!resetn)
      bnd && any_rst |=> !save_we_q && !redirect_q && hold_q)
      else $error("interrupt taken at reset boundary");
   a_inhibit_io: assert property (@(posedge clock) disable iff (!resetn)
      bnd && inhibit_q && !pe_any && !ct_any |=> !save_we_q)
      else $error("io taken while inhibited");
   a_halt_repeat: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && pe_mask_q && |fault_evt |=> halt_q [*2])
      else $error("no halt on repeated processor error");
   a_only_boundary: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && !instr_done |=> !save_we_q && $stable(cc_q))
      else $error("action outside instruction boundary");
   a_ct_over_io: assert property (@(posedge clock) disable iff (!resetn)
      bnd && ct_any && !pe_any && !pe_mask_q && !ct_mask_q && !any_rst |=> redirect_q && redirect_addr_q == pis_pkg::CT_VEC)
      else $error("contingency not taken ahead of input-output");
   a_halted_frozen: assert property (@(posedge clock) disable iff (!resetn)
      halt_q |=> !save_we_q && $stable(cc_q))
      else $error("sequencing went on after halt");
endmodule // pis_sequencer

// *** sim/pis_mem_model.sv ***
// save-word memory on the far side: records each saved control-counter word
// assumes the sequencer's save and redirect pulses on the shared machine clock
`timescale 1ns/1ps
module pis_mem_model (
   input wire logic clock,
   input wire logic resetn,
   input wire logic save_we_q,
   input wire logic [14:0] save_addr_q,
   input wire logic [24:0] save_data_q,
   input wire logic redirect_q,
   input wire logic [14:0] redirect_addr_q,
   output logic [7:0] wr_cnt,
   output logic [14:0] last_addr,
   output logic [24:0] last_data,
   output logic pair_err
);
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wr_cnt <= 8'h00;
         last_addr <= 15'h0000;
         last_data <= 25'h0000000;
         pair_err <= 1'b0;
      end else begin
         if (save_we_q) begin
            wr_cnt <= wr_cnt + 8'h01;
            last_addr <= save_addr_q;
            last_data <= save_data_q;
         end
         // vector word sits right after the save word
         if (save_we_q != redirect_q || (save_we_q && redirect_addr_q != save_addr_q + 15'h0001)) begin
            pair_err <= 1'b1;
         end
      end
   end
endmodule // pis_mem_model

// *** sim/test_priority_interrupt_sequencer.sv ***
// self-checking bench for the priority interrupt sequencer
// assumes pis_pkg, pis_sequencer and the save-word memory model
`timescale 1ns/1ps
module test_priority_interrupt_sequencer;
   logic clock, resetn, clk_en, instr_done, branch_valid, save_we_q, redirect_q, halt_q, pair_err;
   logic [14:0] branch_addr, cc_q, save_addr_q, redirect_addr_q, ecc, last_addr;
   logic [24:0] save_data_q, last_data;
   logic [4:0] kq;
   logic [1:0] fe, bresp, rresp;
   logic [6:0] ce;
   logic [7:0] ii, di, fi, fs, awaddr, araddr, wr_cnt;
   logic [31:0] wdata, rdata;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   int err_count, checks, cyc;

   pis_sequencer u_pis_sequencer (.clock(clock), .resetn(resetn), .clk_en(clk_en), .instr_done(instr_done),
      .branch_valid(branch_valid), .branch_addr(branch_addr), .fault_reset_instr(kq[0]),
      .contingency_reset_instr(kq[1]), .io_reset_instr(kq[2]), .io_inhibit_instr(kq[3]),
      .io_allow_instr(kq[4]), .fault_evt(fe), .cont_evt(ce), .io_init_evt(ii), .io_done_evt(di),
      .io_fault_evt(fi), .io_fs_intr(fs), .cc_q(cc_q), .save_we_q(save_we_q), .save_addr_q(save_addr_q),
      .save_data_q(save_data_q), .redirect_q(redirect_q), .redirect_addr_q(redirect_addr_q), .halt_q(halt_q),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));

   pis_mem_model u_pis_mem_model (.clock(clock), .resetn(resetn), .save_we_q(save_we_q),
      .save_addr_q(save_addr_q), .save_data_q(save_data_q), .redirect_q(redirect_q),
      .redirect_addr_q(redirect_addr_q), .wr_cnt(wr_cnt), .last_addr(last_addr), .last_data(last_data),
      .pair_err(pair_err));

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      cmp(32'(bresp), 32'(er));
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      cmp(rdata, exp);
      cmp(32'(rresp), 32'(er));
   endtask

   task automatic evt(input logic [1:0] f, input logic [7:0] i, input logic [7:0] d, input logic [7:0] x,
                      input logic [7:0] s);
      @(posedge clock);
      fe <= f;
      ii <= i;
      di <= d;
      fi <= x;
      fs <= s;
      @(posedge clock);
      fe <= 2'h0;
      ii <= 8'h00;
      di <= 8'h00;
      fi <= 8'h00;
      #1;
   endtask

   // one instruction boundary; take says whether an interrupt to vec is expected
   task automatic bnd(input logic [4:0] k, input logic [6:0] c, input logic [15:0] br, input logic [14:0] vec,
                      input logic take);
      logic [14:0] nx;
      nx = br[15] ? br[14:0] : ecc + 15'h0001;
      @(posedge clock);
      instr_done <= 1'b1;
      kq <= k;
      ce <= c;
      branch_valid <= br[15];
      branch_addr <= br[14:0];
      @(posedge clock);
      instr_done <= 1'b0;
      kq <= 5'h00;
      ce <= 7'h00;
      branch_valid <= 1'b0;
      #1;
      cmp(32'(save_we_q), 32'(take));
      cmp(32'(redirect_q), 32'(take));
      if (take) begin
         cmp(32'(save_addr_q), 32'(vec - 15'h0001));
         cmp(32'(save_data_q), {17'h00000, nx});
         cmp(32'(redirect_addr_q), 32'(vec));
         ecc = vec;
      end else begin
         ecc = nx;
      end
      cmp(32'(cc_q), 32'(ecc));
   endtask

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         end_sim;
      end
   end

   initial begin
      {resetn, instr_done, branch_valid, awvalid, wvalid, bready, arvalid, rready} = '0;
      {kq, fe, ce, ii, di, fi, fs, awaddr, araddr, wdata, branch_addr, ecc} = '0;
      clk_en = 1'b1;
      err_count = 0;
      checks = 0;
      cyc = 0;
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      #1;
      cmp(32'(cc_q), 32'h00000000);
      axi_rd(pis_pkg::REG_STATUS, 32'h00000000, pis_pkg::RESP_OKAY);
      axi_rd(8'h10, 32'h00000000, pis_pkg::RESP_SLVERR);
      axi_wr(8'h10, 32'h00000001, pis_pkg::RESP_SLVERR);
      $display("test reset done");
      axi_wr(pis_pkg::REG_CONT, 32'h00000001, pis_pkg::RESP_OKAY);
      bnd(5'h00, 7'h00, 16'h8123, pis_pkg::CT_VEC, 1'b1);
      axi_rd(pis_pkg::REG_STATUS, 32'h00000082, pis_pkg::RESP_OKAY);
      axi_wr(pis_pkg::REG_CONT, 32'h00000002, pis_pkg::RESP_OKAY);
      bnd(5'h00, 7'h00, 16'h0000, 15'h0000, 1'b0);
      evt(2'h1, 8'h00, 8'h00, 8'h00, 8'h00);
      bnd(5'h00, 7'h00, 16'h0000, pis_pkg::PE_VEC, 1'b1);
      axi_rd(pis_pkg::REG_STATUS, 32'h000000C3, pis_pkg::RESP_OKAY);
      $display("test priority done");
      bnd(5'h01, 7'h00, 16'h0000, 15'h0000, 1'b0);
      axi_rd(pis_pkg::REG_CONT, 32'h00000003, pis_pkg::RESP_OKAY);
      bnd(5'h02, 7'h04, 16'h0000, 15'h0000, 1'b0);
      bnd(5'h00, 7'h00, 16'h0000, pis_pkg::CT_VEC, 1'b1);
      bnd(5'h02, 7'h00, 16'h0000, 15'h0000, 1'b0);
      bnd(5'h00, 7'h00, 16'h0000, 15'h0000, 1'b0);
      $display("test class reset done");
      bnd(5'h08, 7'h00, 16'h0000, 15'h0000, 1'b0);
      evt(2'h0, 8'h09, 8'h04, 8'h04, 8'h0C);
      axi_rd(pis_pkg::REG_IO, 32'h00040008, pis_pkg::RESP_OKAY);
      bnd(5'h00, 7'h00, 16'h0000, 15'h0000, 1'b0);
      bnd(5'h04, 7'h00, 16'h0000, 15'h0000, 1'b0);
      bnd(5'h10, 7'h00, 16'h0000, 15'h0000, 1'b0);
      axi_rd(pis_pkg::REG_IO, 32'h00000000, pis_pkg::RESP_OKAY);
      evt(2'h0, 8'h00, 8'h00, 8'h02, 8'h00);
      bnd(5'h00, 7'h00, 16'h0000, pis_pkg::IO_VEC, 1'b1);
      // the memory model records the save word one edge after the pulse appears
      @(posedge clock);
      #1;
      cmp(32'(last_addr), 32'(pis_pkg::IO_SAVE));
      cmp(32'(wr_cnt), 32'h00000004);
      // a boundary and a fault event while the clock enable is low must be ignored
      @(posedge clock);
      clk_en <= 1'b0;
      instr_done <= 1'b1;
      fe <= 2'h1;
      @(posedge clock);
      clk_en <= 1'b1;
      instr_done <= 1'b0;
      fe <= 2'h0;
      #1;
      cmp(32'(cc_q), 32'(ecc));
      cmp(32'(save_we_q), 32'h00000000);
      axi_rd(pis_pkg::REG_CONT, 32'h00000000, pis_pkg::RESP_OKAY);
      $display("test io done");
      evt(2'h2, 8'h00, 8'h00, 8'h00, 8'h00);
      bnd(5'h00, 7'h00, 16'h0000, pis_pkg::PE_VEC, 1'b1);
      evt(2'h1, 8'h00, 8'h00, 8'h00, 8'h00);
      cmp(32'(halt_q), 32'h00000001);
      axi_rd(pis_pkg::REG_STATUS, 32'h00000165, pis_pkg::RESP_OKAY);
      cmp(32'(pair_err), 32'h00000000);
      $display("test halt done");
      end_sim;
   end
endmodule // test_priority_interrupt_sequencer
